// >>> debug_link_pkg.sv
/*
  Shared constants and types for both ends of the two-wire debug link and its
  flash programming data port.
  Assumes one system clock of 40 MHz at each end and a pulled-up data line.
*/
package debug_link_pkg;

  // ------------------------------------------------------------------
  // Link register map and codes
  // ------------------------------------------------------------------
  localparam logic [7:0] SEL_CONTROL       = 8'h02;
  localparam logic [7:0] SEL_DATA          = 8'hb4;
  localparam logic [7:0] REG_RESET         = 8'h00;
  localparam logic [7:0] CMD_BLOCK_READ    = 8'h06;
  localparam logic [7:0] CMD_BLOCK_WRITE   = 8'h07;
  localparam logic [7:0] CMD_PAGE_ERASE    = 8'h08;
  localparam logic [7:0] CMD_DEVICE_ERASE  = 8'h03;
  localparam logic [7:0] ENABLE_KEY_FIRST  = 8'h02;
  localparam logic [7:0] ENABLE_KEY_SECOND = 8'h01;

  typedef enum logic [1:0] {
    OP_WRITE_SELECT,
    OP_READ_SELECT,
    OP_WRITE_DATA,
    OP_READ_DATA
  } link_op_t;

  // ------------------------------------------------------------------
  // Frame bit counts and timing
  // ------------------------------------------------------------------
  localparam logic [3:0] CNT_START      = 4'h1;
  localparam logic [3:0] CNT_OP_DONE    = 4'h3;
  localparam logic [3:0] CNT_DATA_DONE  = 4'hb;
  localparam logic [3:0] BITS_WRITE     = 4'hc;
  localparam logic [3:0] BITS_READ      = 4'hb;
  localparam int         CLK_PERIOD_NS  = 25;
  localparam int         LINK_PERIOD_NS = 200;
  localparam int         LINK_DIV       = (LINK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // Flash side buffer and host register bus
  // ------------------------------------------------------------------
  localparam int         FIFO_DEPTH     = 4;
  localparam int         FLASH_W        = 9;
  localparam logic [3:0] WB_CMD_ADDR    = 4'h0;
  localparam logic [3:0] WB_STATUS_ADDR = 4'h4;

endpackage : debug_link_pkg

// >>> two_wire_debug_link_if.sv
/*
  The two-wire debug link between host adapter and device.
  Assumes a pull-up on the data line; the wire level is resolved here.
*/
`timescale 1ns/1ps
interface two_wire_debug_link_if;
  logic link_clock_pin;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic link_data_pin;

  // Host wins a collision so that a fault shows as a wrong bit, not an X.
  assign link_data_pin = host_data_oe ? host_data_o : (dev_data_oe ? dev_data_o : 1'b1);

  modport host (
    output link_clock_pin,
    output host_data_o,
    output host_data_oe,
    input  link_data_pin
  );
  modport device (
    input  link_clock_pin,
    input  link_data_pin,
    output dev_data_o,
    output dev_data_oe
  );
endinterface : two_wire_debug_link_if

// >>> debug_link_device.sv
/*
  Device end of the two-wire debug link: link receiver, link registers,
  command decoder and the buffer toward the flash controller.
  Assumes the host makes the link clock and the flash side drains the buffer.
*/
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Buffer
// ------------------------------------------------------------------
module debug_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic        push;
  logic        pop;

  assign in_ready_o  = (st.count != CW'(DEPTH));
  assign out_valid_o = (st.count != '0);
  assign out_data_o  = st.mem[st.rd];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data_i;
      next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + AW'(1);
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + AW'(1);
    end
    if (push && !pop) begin
      next_st.count = st.count + CW'(1);
    end else if (pop && !push) begin
      next_st.count = st.count - CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : debug_fifo

// ------------------------------------------------------------------
// Device end
// ------------------------------------------------------------------
module debug_link_device #(
  parameter int FIFO_DEPTH = debug_link_pkg::FIFO_DEPTH
) (
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  two_wire_debug_link_if.device                   link,
  input  wire logic                               halted_i,
  input  wire logic                               flash_ready_i,
  output logic                                    flash_valid_o,
  output logic      [debug_link_pkg::FLASH_W-1:0] flash_data_o,
  input  wire logic                               flash_done_i,
  input  wire logic                               flash_rdata_valid_i,
  input  wire logic [7:0]                         flash_rdata_i,
  output logic                                    stall_o,
  output logic                                    prog_enabled_o,
  output logic                                    user_data_o,
  output logic                                    user_reset_o
);
  import debug_link_pkg::*;

  typedef struct packed {
    logic [1:0]   ck_sync;
    logic [1:0]   d_sync;
    logic         ck_prev;
    logic         in_frame;
    logic [3:0]   cnt;
    link_op_t     op;
    logic [7:0]   shift;
    logic         oe;
    logic         dout;
    logic         ack;
    logic [7:0]   target_select_reg;
    logic [7:0]   programming_control_reg;
    logic [7:0]   programming_data_reg;
    logic         key_armed;
    logic         prog_enabled;
    logic         expect_cmd;
    logic         push;
    logic [FLASH_W-1:0] push_data;
    logic         user_data;
    logic         user_reset;
  } dev_state_t;

  dev_state_t st;
  dev_state_t next_st;
  logic       fifo_ready;
  logic       rise;
  logic       fall;
  logic       din;
  link_op_t   nop;

  // ------------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------------
  function automatic logic is_read(input link_op_t op);
    is_read = (op == OP_READ_SELECT) || (op == OP_READ_DATA);
  endfunction : is_read

  function automatic logic is_command(input logic [7:0] b);
    is_command = (b == CMD_BLOCK_READ) || (b == CMD_BLOCK_WRITE) ||
                 (b == CMD_PAGE_ERASE) || (b == CMD_DEVICE_ERASE);
  endfunction : is_command

  function automatic logic [7:0] read_value(input link_op_t op, input dev_state_t s);
    read_value = REG_RESET;
    if (op == OP_READ_SELECT) begin
      read_value = s.target_select_reg;
    end else if (s.target_select_reg == SEL_CONTROL) begin
      read_value = s.programming_control_reg;
    end else if (s.target_select_reg == SEL_DATA) begin
      read_value = s.programming_data_reg;
    end
  endfunction : read_value

  function automatic dev_state_t commit(input dev_state_t s, input logic [7:0] b,
                                        input logic room);
    commit     = s;
    commit.ack = 1'b1;
    if (s.op == OP_WRITE_SELECT) begin
      commit.target_select_reg = b;
    end else if (s.target_select_reg == SEL_CONTROL) begin
      commit.programming_control_reg = b;
      commit.key_armed = (b == ENABLE_KEY_FIRST);
      if (s.key_armed && b == ENABLE_KEY_SECOND) begin
        commit.prog_enabled = 1'b1;
      end
    end else if (s.target_select_reg == SEL_DATA) begin
      // A full buffer refuses the byte; the host sees a low answer bit.
      if (!room) begin
        commit.ack = 1'b0;
      end else begin
        commit.programming_data_reg = b;
        if (s.prog_enabled && s.expect_cmd) begin
          if (is_command(b)) begin
            commit.push       = 1'b1;
            commit.push_data  = {1'b1, b};
            commit.expect_cmd = 1'b0;
          end
        end else if (s.prog_enabled) begin
          commit.push      = 1'b1;
          commit.push_data = {1'b0, b};
        end
      end
    end
  endfunction : commit

  // ------------------------------------------------------------------
  // Link receiver and registers
  // ------------------------------------------------------------------
  assign rise = st.ck_sync[1] & ~st.ck_prev;
  assign fall = ~st.ck_sync[1] & st.ck_prev;
  assign din  = st.d_sync[1];
  assign nop  = link_op_t'({din, st.op[1]});

  always_comb begin
    next_st         = st;
    next_st.push    = 1'b0;
    next_st.ck_sync = {st.ck_sync[0], link.link_clock_pin};
    next_st.d_sync  = {st.d_sync[0], link.link_data_pin};
    next_st.ck_prev = st.ck_sync[1];
    if (!halted_i) begin
      next_st.in_frame   = 1'b0;
      next_st.oe         = 1'b0;
      next_st.user_data  = st.d_sync[1];
      next_st.user_reset = st.ck_sync[1];
    end else begin
      // The user copy is frozen; safe only because that input holds still.
      if (fall) begin
        next_st.oe = st.in_frame &&
                     ((is_read(st.op) && st.cnt >= CNT_OP_DONE && st.cnt < CNT_DATA_DONE) ||
                      (!is_read(st.op) && st.cnt == CNT_DATA_DONE));
        next_st.dout = is_read(st.op) ? st.shift[0] : st.ack;
      end
      if (rise) begin
        if (!st.in_frame) begin
          if (!din) begin
            next_st.in_frame = 1'b1;
            next_st.cnt      = CNT_START;
          end
        end else begin
          next_st.cnt = st.cnt + 4'h1;
          if (st.cnt < CNT_OP_DONE) begin
            next_st.op = nop;
          end
          if (st.cnt == CNT_OP_DONE - 4'h1 && is_read(nop)) begin
            next_st.shift = read_value(nop, st);
          end
          if (st.cnt >= CNT_OP_DONE && st.cnt < CNT_DATA_DONE) begin
            next_st.shift = {is_read(st.op) ? 1'b0 : din, st.shift[7:1]};
          end
          if (st.cnt == CNT_DATA_DONE - 4'h1) begin
            if (is_read(st.op)) begin
              next_st.in_frame = 1'b0;
            end else begin
              next_st = commit(next_st, {din, st.shift[7:1]}, fifo_ready);
            end
          end
          if (st.cnt == CNT_DATA_DONE) begin
            next_st.in_frame = 1'b0;
          end
        end
      end
    end
    // Hardware sources come last so that they win over a same-cycle link write.
    if (flash_rdata_valid_i) begin
      next_st.programming_data_reg = flash_rdata_i;
    end
    if (flash_done_i) begin
      next_st.expect_cmd = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st                         <= '0;
      st.ck_sync                 <= 2'h0;
      st.d_sync                  <= 2'h3;
      st.target_select_reg       <= REG_RESET;
      st.programming_control_reg <= REG_RESET;
      st.programming_data_reg    <= REG_RESET;
      st.expect_cmd              <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // Outputs and flash buffer
  // ------------------------------------------------------------------
  assign link.dev_data_o  = st.dout;
  assign link.dev_data_oe = st.oe & halted_i;
  assign stall_o          = halted_i | st.prog_enabled;
  assign prog_enabled_o   = st.prog_enabled;
  assign user_data_o      = st.user_data;
  assign user_reset_o     = st.user_reset;

  debug_fifo #(
    .WIDTH (FLASH_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (st.push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (st.push_data),
    .out_valid_o (flash_valid_o),
    .out_ready_i (flash_ready_i),
    .out_data_o  (flash_data_o)
  );

endmodule : debug_link_device

// >>> debug_link_host.sv
/*
  Host adapter end of the two-wire debug link with a Wishbone classic slave
  for its command and status registers.
  Assumes a device that answers within one half link period.
*/
`timescale 1ns/1ps
module debug_link_host #(
  parameter int LINK_DIV = debug_link_pkg::LINK_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  two_wire_debug_link_if.host link
);
  import debug_link_pkg::*;

  typedef enum logic {H_IDLE, H_RUN} host_mode_t;

  typedef struct packed {
    host_mode_t  mode;
    logic [7:0]  phase;
    logic [3:0]  bitn;
    link_op_t    op;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic        ack;
    logic [1:0]  d_sync;
    logic        clk_out;
    logic        oe;
    logic        dout;
    logic        wb_ack;
    logic [31:0] wb_dat;
  } host_state_t;

  host_state_t st;
  host_state_t next_st;
  logic        accept;
  logic        wr_op;
  logic [3:0]  last;

  assign accept = wb_cyc_i & wb_stb_i & ~st.wb_ack;
  assign wr_op  = (st.op == OP_WRITE_SELECT) || (st.op == OP_WRITE_DATA);
  assign last   = wr_op ? BITS_WRITE : BITS_READ;

  // ------------------------------------------------------------------
  // Register bus and frame sequencer
  // ------------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.wb_ack = accept;
    next_st.d_sync = {st.d_sync[0], link.link_data_pin};
    if (accept) begin
      case (wb_adr_i)
        WB_CMD_ADDR:    next_st.wb_dat = {22'h0, st.op, st.tx};
        WB_STATUS_ADDR: next_st.wb_dat = {16'h0, st.rx, 6'h0, st.ack, st.mode == H_RUN};
        default:        next_st.wb_dat = 32'h0;
      endcase
      // A command written while a frame runs is dropped; poll busy first.
      if (wb_we_i && wb_adr_i == WB_CMD_ADDR && wb_sel_i[1:0] == 2'h3 &&
          st.mode == H_IDLE) begin
        next_st.op    = link_op_t'(wb_dat_i[9:8]);
        next_st.tx    = wb_dat_i[7:0];
        next_st.mode  = H_RUN;
        next_st.phase = 8'h0;
        next_st.bitn  = 4'h0;
      end
    end
    case (st.mode)
      H_IDLE: begin
        next_st.clk_out = 1'b0;
        next_st.oe      = 1'b0;
      end
      H_RUN: begin
        next_st.phase   = (st.phase == 8'(LINK_DIV - 1)) ? 8'h0 : st.phase + 8'h1;
        next_st.clk_out = (next_st.phase >= 8'(LINK_DIV / 2)) && (st.bitn < last);
        if (st.phase == 8'h0) begin
          next_st.oe   = 1'b0;
          next_st.dout = 1'b1;
          if (st.bitn == 4'h0) begin
            next_st.oe   = 1'b1;
            next_st.dout = 1'b0;
          end else if (st.bitn < CNT_OP_DONE) begin
            next_st.oe   = 1'b1;
            next_st.dout = st.op[st.bitn[0] ? 0 : 1];
          end else if (wr_op && st.bitn < CNT_DATA_DONE) begin
            next_st.oe   = 1'b1;
            next_st.dout = st.tx[3'(st.bitn - CNT_OP_DONE)];
          end
        end
        if (st.phase == 8'(LINK_DIV - 1)) begin
          if (!wr_op && st.bitn >= CNT_OP_DONE && st.bitn < CNT_DATA_DONE) begin
            next_st.rx = {st.d_sync[1], st.rx[7:1]};
          end
          if (wr_op && st.bitn == CNT_DATA_DONE) begin
            next_st.ack = st.d_sync[1];
          end
          next_st.bitn = st.bitn + 4'h1;
          if (st.bitn == last) begin
            next_st.mode = H_IDLE;
          end
        end
      end
      default: next_st.mode = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st        <= '0;
      st.mode   <= H_IDLE;
      st.d_sync <= 2'h3;
      st.dout   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o            = st.wb_ack;
  assign wb_dat_o            = st.wb_dat;
  assign link.link_clock_pin = st.clk_out;
  assign link.host_data_o    = st.dout;
  assign link.host_data_oe   = st.oe;

endmodule : debug_link_host

// >>> debug_link_asserts.sv
/*
  Concurrent checks on the link between the two ends and on the device end's
  halt, stall, enable and buffer outputs.
  Assumes the default link divide of 8 system clocks per link period.
*/
`timescale 1ns/1ps
module debug_link_asserts
  import debug_link_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               link_clock_pin,
  input wire logic               dev_data_oe,
  input wire logic               halted_i,
  input wire logic               stall_o,
  input wire logic               prog_enabled_o,
  input wire logic               user_data_o,
  input wire logic               user_reset_o,
  input wire logic               flash_valid_o,
  input wire logic               flash_ready_i,
  input wire logic [FLASH_W-1:0] flash_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  property p_reset_clear;
    $fell(rst_i) |-> !prog_enabled_o && !flash_valid_o && !dev_data_oe;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not clear after reset");
  property p_head_hold;
    flash_valid_o && !flash_ready_i |=> flash_valid_o && $stable(flash_data_o);
  endproperty
  a_head_hold: assert property (p_head_hold) else $error("buffer head changed unread");
  property p_user_data_hold;
    halted_i && $past(halted_i) |-> $stable(user_data_o);
  endproperty
  a_user_data_hold: assert property (p_user_data_hold) else $error("user data moved");
  property p_stall_halt;
    halted_i |-> stall_o;
  endproperty
  a_stall_halt: assert property (p_stall_halt) else $error("halt without stall");
  property p_drive_halted;
    dev_data_oe |-> halted_i;
  endproperty
  a_drive_halted: assert property (p_drive_halted) else $error("data driven while running");
  property p_user_reset_hold;
    halted_i && $past(halted_i) |-> $stable(user_reset_o);
  endproperty
  a_user_reset_hold: assert property (p_user_reset_hold) else $error("user reset moved");
  // The bit time is fixed by the divide of 8, so the high phase is four cycles.
  property p_clock_high;
    $rose(link_clock_pin) |-> link_clock_pin[*4] ##1 !link_clock_pin;
  endproperty
  a_clock_high: assert property (p_clock_high) else $error("link clock high phase wrong");
  property p_answer_stands;
    $rose(dev_data_oe) |-> (dev_data_oe || !halted_i)[*4];
  endproperty
  a_answer_stands: assert property (p_answer_stands) else $error("device bit too short");
  property p_enable_sticky;
    prog_enabled_o |=> prog_enabled_o && stall_o;
  endproperty
  a_enable_sticky: assert property (p_enable_sticky) else $error("enable lost");

  c_enable: cover property ($rose(prog_enabled_o));
  c_answer: cover property ($rose(dev_data_oe));
  c_pop:    cover property (flash_valid_o && flash_ready_i);
endmodule : debug_link_asserts

// >>> tb.sv
/*
  Testbench joining host and device ends over the link interface.
  Assumes host register offsets and frame layout as handed over by the designer.
*/
`timescale 1ns/1ps
module tb;
  import debug_link_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        halted;
  logic        fl_ready;
  logic        fl_done;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] wb_q;
  logic        ack;
  logic        fl_valid;
  logic [8:0]  fl_data;
  logic        stall;
  logic        prog_en;
  logic        user_d;
  logic        user_r;
  logic [7:0]  rb;
  logic        ans;
  logic [7:0]  cmds [4] = '{CMD_BLOCK_READ, CMD_BLOCK_WRITE, CMD_PAGE_ERASE, CMD_DEVICE_ERASE};
  int          err_total;
  int          compares;
  int          cycles;

  two_wire_debug_link_if link_if();
  debug_link_host debug_link_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_q), .wb_ack_o(ack), .link(link_if));
  debug_link_device debug_link_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(link_if),
    .halted_i(halted), .flash_ready_i(fl_ready), .flash_valid_o(fl_valid),
    .flash_data_o(fl_data), .flash_done_i(fl_done), .flash_rdata_valid_i(rd_valid),
    .flash_rdata_i(rd_data), .stall_o(stall), .prog_enabled_o(prog_en),
    .user_data_o(user_d), .user_reset_o(user_r));
  debug_link_asserts debug_link_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
    .link_clock_pin(link_if.link_clock_pin), .dev_data_oe(link_if.dev_data_oe),
    .halted_i(halted), .stall_o(stall), .prog_enabled_o(prog_en), .user_data_o(user_d),
    .user_reset_o(user_r), .flash_valid_o(fl_valid), .flash_ready_i(fl_ready),
    .flash_data_o(fl_data));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic wrap_up();
    $display("errors %0d, comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic fault(input string msg);
    err_total++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : fault

  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) fault($sformatf("bit %b, wanted %b", got, exp));
  endtask : check_bit

  task automatic check_val(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) fault($sformatf("value %h, wanted %h", got, exp));
  endtask : check_val

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    // Only the bench timeout ends this wait; the slave sets the pace.
    do begin
      @(posedge clk_i);
    end while (ack !== 1'h1);
    q = wb_q;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb

  // One link frame started through the command register, then polled to idle.
  task automatic lop(input link_op_t op, input logic [7:0] b);
    logic [31:0] q;
    int          n;
    n = 0;
    wb(1'h1, WB_CMD_ADDR, {22'h0, op, b}, q);
    do begin
      wb(1'h0, WB_STATUS_ADDR, 32'h0, q);
      n++;
    end while (q[0] !== 1'h0 && n < 100);
    rb  = q[15:8];
    ans = q[1];
    if (n >= 100) fault("frame never ended");
  endtask : lop

  task automatic pop(input logic [8:0] exp);
    int n;
    n = 0;
    // Look at the buffer only at an edge, after an earlier pop has settled.
    @(posedge clk_i);
    while (fl_valid !== 1'h1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    check_val(fl_data, exp);
    fl_ready <= 1'h1;
    @(posedge clk_i);
    fl_ready <= 1'h0;
  endtask : pop

  task automatic done_pulse();
    @(posedge clk_i);
    fl_done <= 1'h1;
    @(posedge clk_i);
    fl_done <= 1'h0;
  endtask : done_pulse

  // ------------------------------------------------------------------
  // Clock, timeout and sequence
  // ------------------------------------------------------------------
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Whole sequence needs about 3200 cycles; the ceiling leaves ample margin.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      fault("timeout");
      wrap_up();
    end
  end

  initial begin
    {rst_i, halted} = 2'h3;
    {cyc, stb, we, fl_ready, fl_done, rd_valid} = 6'h0;
    {adr, sel, wdat, rd_data} = 48'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    check_bit(stall, 1'h1);
    lop(OP_WRITE_SELECT, SEL_DATA);
    lop(OP_READ_SELECT, 8'h00);
    check_val({1'h0, rb}, {1'h0, SEL_DATA});
    lop(OP_READ_DATA, 8'h00);
    check_val({1'h0, rb}, {1'h0, REG_RESET});
    lop(OP_WRITE_DATA, 8'h5a);
    lop(OP_READ_DATA, 8'h00);
    check_val({1'h0, rb}, 9'h05a);
    lop(OP_WRITE_DATA, CMD_BLOCK_READ);
    repeat (4) @(posedge clk_i);
    check_bit(fl_valid, 1'h0);
    lop(OP_WRITE_SELECT, SEL_CONTROL);
    lop(OP_WRITE_DATA, ENABLE_KEY_SECOND);
    check_bit(prog_en, 1'h0);
    lop(OP_WRITE_DATA, ENABLE_KEY_FIRST);
    lop(OP_WRITE_DATA, ENABLE_KEY_SECOND);
    check_bit(prog_en, 1'h1);
    lop(OP_WRITE_SELECT, SEL_DATA);
    foreach (cmds[i]) begin
      lop(OP_WRITE_DATA, cmds[i]);
      pop({1'h1, cmds[i]});
      lop(OP_WRITE_DATA, 8'h3c);
      pop(9'h03c);
      done_pulse();
    end
    lop(OP_WRITE_DATA, 8'h55);
    repeat (4) @(posedge clk_i);
    check_bit(fl_valid, 1'h0);
    lop(OP_READ_DATA, 8'h00);
    check_val({1'h0, rb}, 9'h055);
    // Drain side stalls while four words fill the buffer; the fifth is turned away.
    lop(OP_WRITE_DATA, CMD_BLOCK_WRITE);
    check_bit(ans, 1'h1);
    for (int i = 0; i < 4; i++) begin
      lop(OP_WRITE_DATA, 8'h10 + 8'(i));
      check_bit(ans, i < 3);
    end
    pop({1'h1, CMD_BLOCK_WRITE});
    for (int i = 0; i < 3; i++) pop(9'h010 + 9'(i));
    @(posedge clk_i);
    check_bit(fl_valid, 1'h0);
    done_pulse();
    @(posedge clk_i);
    rd_data  <= 8'hc3;
    rd_valid <= 1'h1;
    @(posedge clk_i);
    rd_valid <= 1'h0;
    lop(OP_READ_DATA, 8'h00);
    check_val({1'h0, rb}, 9'h0c3);
    check_bit(user_d, 1'h0);
    halted <= 1'h0;
    lop(OP_READ_DATA, 8'h00);
    check_val({1'h0, rb}, 9'h0ff);
    check_bit(stall, 1'h1);
    check_bit(user_d, 1'h1);
    check_bit(user_r, 1'h0);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    check_bit(prog_en, 1'h0);
    check_bit(stall, 1'h0);
    wrap_up();
  end
endmodule : tb
